/* File: csv_pkg.sv */
// Shared constants and types for the status, vector and stack block
`default_nettype none
package csv_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_CMD   = 8'h00;
  localparam logic [7:0] OFF_OPND  = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_PC    = 8'h0c;
  localparam logic [7:0] OFF_STACK = 8'h10;
  localparam logic [7:0] OFF_RES   = 8'h14;
  localparam logic [7:0] OFF_DADR  = 8'h18;
  localparam logic [7:0] OFF_VEC_LO = 8'h40;
  localparam logic [7:0] OFF_VEC_HI = 8'h7c;

  // Status word bit placement
  localparam int FL_CARRY = 0;
  localparam int FL_ZERO  = 1;
  localparam int FL_INT   = 2;
  localparam int FL_HALF  = 3;
  localparam int FL_BREAK = 4;
  localparam int FL_DPAGE = 5;
  localparam int FL_OVF   = 6;
  localparam int FL_NEG   = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Program memory vector page, low six address bits index it
  localparam logic [15:0] VEC_PAGE   = 16'hffc0;
  localparam logic [15:0] VEC_RESET  = 16'hfffe;
  localparam logic [15:0] VEC_TBL0   = 16'hffde;
  localparam logic [15:0] VEC_EXT0   = 16'hfffa;
  localparam logic [15:0] VEC_EXT1   = 16'hfff8;
  localparam logic [15:0] VEC_TMR0   = 16'hfff6;
  localparam logic [15:0] VEC_TMR1   = 16'hfff4;
  localparam logic [15:0] VEC_ADC    = 16'hffea;
  localparam logic [15:0] VEC_WDOG   = 16'hffe8;
  localparam logic [15:0] VEC_IVTMR  = 16'hffe6;
  localparam logic [15:0] VEC_SERIAL = 16'hffe4;

  // Data space
  localparam logic [7:0] CTRL_WIN_LO = 8'hc0;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [31:0] OPND_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [4:0] {
    OP_NOP, OP_ENA_INT, OP_DIS_INT, OP_CLR_OVF, OP_SET_DP, OP_CLR_DP,
    OP_ADD, OP_SUB, OP_BIT_TEST, OP_LOAD, OP_CALL, OP_TBL_CALL,
    OP_SW_BREAK, OP_SUB_RETURN, OP_INT_RETURN, OP_INT_ACCEPT,
    OP_STEP, OP_BOOT
  } csv_op_t;

  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_PUSH, ST_POP} csv_fsm_t;

  typedef struct packed {
    csv_fsm_t    fsm;
    logic [15:0] pc;
    logic [7:0]  stack_ptr;
    logic [7:0]  status_word;
    logic [1:0]  cnt;
    logic [1:0]  last;
    logic [15:0] target;
    logic [7:0]  saved;
    logic [7:0]  result;
    logic [31:0] opnd;
    logic [7:0]  daddr;
    logic        refused;
    logic        awready;
    logic        wready;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } csv_state_t;
endpackage
`default_nettype wire

/* File: csv_core.sv */
// Status word, vectors, program counter and stack of the CPU core
// Contract
// - Interrupt acceptance refused while interrupt enable is zero; break still works.
// - Accepting an interrupt clears the interrupt enable flag immediately.
// - Enable-interrupts sets the enable flag, disable-interrupts clears it.
// - Half carry set on carry from bit 3 or no borrow from bit 4.
// - Only arithmetic and clear-overflow change half carry; clear-overflow clears it. Interrupt return here also reloads it from the stack.
// - Software break sets the break flag.
// - Direct address lies in 00h-FFh, or 100h-1FFh with direct page set.
// - Set-direct-page sets the page flag, clear-direct-page clears it.
// - Overflow flag set when signed add or subtract leaves -128..+127.
// - Clear-overflow clears overflow; no command sets it explicitly.
// - Bit test copies operand bit 6 to overflow and bit 7 to negative.
// - Negative flag equals bit 7 of every data or arithmetic result.
// - Program counter wraps from FFFFh to 0000h.
// - After reset the start address is fetched from FFFEh and FFFFh.
// - Table call n jumps through the vector at FFC0h plus 2*(15-n).
// - Interrupt vectors are two-byte entries, external 1 at FFF8h, 0 at FFFAh.
// - Control register window is data addresses 0C0h to 0FFh.
// - Unoccupied window addresses need not be implemented.
// - Calls and accepted interrupts push the return address before jumping.
// - Subroutine return restores PC only; interrupt return restores PC and flags.
// - Stack pointer decrements after each save, increments before each restore.
// - Stack bytes sit at 100h plus the stack pointer.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module csv_core #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output var  logic              S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output var  logic              S_AXI_WREADY,
  output var  logic [1:0]        S_AXI_BRESP,
  output var  logic              S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output var  logic              S_AXI_ARREADY,
  output var  logic [31:0]       S_AXI_RDATA,
  output var  logic [1:0]        S_AXI_RRESP,
  output var  logic              S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY
);
  csv_pkg::csv_state_t s_q;
  csv_pkg::csv_state_t s_d;

  logic [7:0]  stack_mem [256];
  logic [31:0] vec_mem [16];

  logic        stk_we;
  logic [7:0]  stk_wd;
  logic        vec_we;
  logic [3:0]  vec_wi;
  logic [31:0] vec_wd;
  logic        exec;
  csv_pkg::csv_op_t op;
  logic [3:0]  arg;
  logic [7:0]  opa;
  logic [7:0]  opb;
  logic [8:0]  sum;
  logic [4:0]  half_sum;
  logic [7:0]  diff;
  logic [7:0]  pop_addr;
  logic [7:0]  pop_data;
  logic [8:0]  eff_addr;
  logic        win_hit;
  logic [15:0] call_tgt;

  assign op       = csv_pkg::csv_op_t'(s_q.w_data[4:0]);
  assign arg      = s_q.w_data[11:8];
  assign opa      = s_q.opnd[7:0];
  assign opb      = s_q.opnd[15:8];
  assign call_tgt = s_q.opnd[31:16];
  assign sum      = {1'b0, opa} + {1'b0, opb};
  assign half_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
  assign diff     = opa - opb;
  assign pop_addr = s_q.stack_ptr + 8'h01;
  assign pop_data = stack_mem[pop_addr];
  // Direct page picks the high half of the 512-byte data space
  assign eff_addr = {s_q.status_word[csv_pkg::FL_DPAGE], s_q.daddr};
  // Window slots are not backed here; software must not rely on them
  assign win_hit  = ~eff_addr[8] && (s_q.daddr >= csv_pkg::CTRL_WIN_LO);

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Little-endian two-byte vector from the top program page
  function automatic logic [15:0] vec16(input logic [5:0] idx);
    logic [5:0] hi;
    hi = idx + 6'h01;
    return {vec_mem[hi[5:2]][{hi[1:0], 3'b000} +: 8],
            vec_mem[idx[5:2]][{idx[1:0], 3'b000} +: 8]};
  endfunction

  function automatic logic [5:0] int_index(input logic [2:0] src);
    logic [15:0] v;
    case (src)
      3'h0:    v = csv_pkg::VEC_EXT0;
      3'h1:    v = csv_pkg::VEC_EXT1;
      3'h2:    v = csv_pkg::VEC_TMR0;
      3'h3:    v = csv_pkg::VEC_TMR1;
      3'h4:    v = csv_pkg::VEC_ADC;
      3'h5:    v = csv_pkg::VEC_WDOG;
      3'h6:    v = csv_pkg::VEC_IVTMR;
      default: v = csv_pkg::VEC_SERIAL;
    endcase
    return v[5:0];
  endfunction

  function automatic logic [33:0] read_mux(input logic [7:0] a);
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'h0000_0000;
    r = csv_pkg::RESP_OKAY;
    if (a == csv_pkg::OFF_CMD) begin
      d = 32'h0000_0000;
    end else if (a == csv_pkg::OFF_OPND) begin
      d = s_q.opnd;
    end else if (a == csv_pkg::OFF_STAT) begin
      d = {7'h00, eff_addr, 5'h00, win_hit, s_q.refused,
           s_q.fsm != csv_pkg::ST_IDLE, s_q.status_word};
    end else if (a == csv_pkg::OFF_PC) begin
      d = {16'h0000, s_q.pc};
    end else if (a == csv_pkg::OFF_STACK) begin
      d = {24'h000000, s_q.stack_ptr};
    end else if (a == csv_pkg::OFF_RES) begin
      d = {24'h000000, s_q.result};
    end else if (a == csv_pkg::OFF_DADR) begin
      d = {24'h000000, s_q.daddr};
    end else if (a >= csv_pkg::OFF_VEC_LO && a <= csv_pkg::OFF_VEC_HI) begin
      d = vec_mem[a[5:2]];
    end else begin
      r = csv_pkg::RESP_SLVERR;
    end
    return {r, d};
  endfunction

  always_comb begin
    s_d    = s_q;
    stk_we = 1'b0;
    stk_wd = 8'h00;
    vec_we = 1'b0;
    vec_wi = s_q.aw_addr[5:2];
    vec_wd = merge(vec_mem[s_q.aw_addr[5:2]], s_q.w_data, s_q.w_strb);
    exec   = 1'b0;
    // Write address and data are held until both are present
    if (s_q.awready && S_AXI_AWVALID) begin
      s_d.aw_addr = S_AXI_AWADDR[7:0];
      s_d.aw_full = 1'b1;
      s_d.awready = 1'b0;
    end
    if (s_q.wready && S_AXI_WVALID) begin
      s_d.w_data = S_AXI_WDATA;
      s_d.w_strb = S_AXI_WSTRB;
      s_d.w_full = 1'b1;
      s_d.wready = 1'b0;
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = csv_pkg::RESP_OKAY;
      if (s_q.aw_addr == csv_pkg::OFF_CMD) begin
        // Commands arriving while a stack sequence runs are dropped
        exec = s_q.w_strb[0] && (s_q.fsm == csv_pkg::ST_IDLE);
      end else if (s_q.aw_addr == csv_pkg::OFF_OPND) begin
        s_d.opnd = merge(s_q.opnd, s_q.w_data, s_q.w_strb);
      end else if (s_q.aw_addr == csv_pkg::OFF_STACK) begin
        if (s_q.w_strb[0]) begin
          s_d.stack_ptr = s_q.w_data[7:0];
        end
      end else if (s_q.aw_addr == csv_pkg::OFF_DADR) begin
        if (s_q.w_strb[0]) begin
          s_d.daddr = s_q.w_data[7:0];
        end
      end else if (s_q.aw_addr >= csv_pkg::OFF_VEC_LO &&
                   s_q.aw_addr <= csv_pkg::OFF_VEC_HI) begin
        vec_we = 1'b1;
      end else if (s_q.aw_addr != csv_pkg::OFF_STAT && s_q.aw_addr != csv_pkg::OFF_PC &&
                   s_q.aw_addr != csv_pkg::OFF_RES) begin
        s_d.bresp = csv_pkg::RESP_SLVERR;
      end
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end
    if (s_q.arready && S_AXI_ARVALID) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      {s_d.rresp, s_d.rdata} = read_mux(S_AXI_ARADDR[7:0]);
    end
    if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end

    case (s_q.fsm)
      csv_pkg::ST_BOOT: begin
        s_d.pc  = vec16(csv_pkg::VEC_RESET[5:0]);
        s_d.fsm = csv_pkg::ST_IDLE;
      end
      csv_pkg::ST_IDLE: begin
        if (exec) begin
          s_d.refused = 1'b0;
          case (op)
            csv_pkg::OP_ENA_INT: s_d.status_word[csv_pkg::FL_INT] = 1'b1;
            csv_pkg::OP_DIS_INT: s_d.status_word[csv_pkg::FL_INT] = 1'b0;
            csv_pkg::OP_CLR_OVF: begin
              s_d.status_word[csv_pkg::FL_OVF]  = 1'b0;
              s_d.status_word[csv_pkg::FL_HALF] = 1'b0;
            end
            csv_pkg::OP_SET_DP: s_d.status_word[csv_pkg::FL_DPAGE] = 1'b1;
            csv_pkg::OP_CLR_DP: s_d.status_word[csv_pkg::FL_DPAGE] = 1'b0;
            csv_pkg::OP_ADD: begin
              s_d.result = sum[7:0];
              s_d.status_word[csv_pkg::FL_CARRY] = sum[8];
              s_d.status_word[csv_pkg::FL_HALF]  = half_sum[4];
              s_d.status_word[csv_pkg::FL_OVF]   =
                (opa[7] == opb[7]) && (sum[7] != opa[7]);
              s_d.status_word[csv_pkg::FL_NEG]   = sum[7];
              s_d.status_word[csv_pkg::FL_ZERO]  = sum[7:0] == 8'h00;
            end
            csv_pkg::OP_SUB: begin
              s_d.result = diff;
              s_d.status_word[csv_pkg::FL_CARRY] = opa >= opb;
              s_d.status_word[csv_pkg::FL_HALF]  = opa[3:0] >= opb[3:0];
              s_d.status_word[csv_pkg::FL_OVF]   =
                (opa[7] != opb[7]) && (diff[7] != opa[7]);
              s_d.status_word[csv_pkg::FL_NEG]   = diff[7];
              s_d.status_word[csv_pkg::FL_ZERO]  = diff == 8'h00;
            end
            csv_pkg::OP_BIT_TEST: begin
              s_d.status_word[csv_pkg::FL_OVF]  = opb[6];
              s_d.status_word[csv_pkg::FL_NEG]  = opb[7];
              s_d.status_word[csv_pkg::FL_ZERO] = (opa & opb) == 8'h00;
            end
            csv_pkg::OP_LOAD: begin
              s_d.result = opb;
              s_d.status_word[csv_pkg::FL_NEG]  = opb[7];
              s_d.status_word[csv_pkg::FL_ZERO] = opb == 8'h00;
            end
            csv_pkg::OP_CALL: begin
              s_d.target = call_tgt;
              s_d.cnt    = 2'd0;
              s_d.last   = 2'd1;
              s_d.fsm    = csv_pkg::ST_PUSH;
            end
            csv_pkg::OP_TBL_CALL: begin
              s_d.target = vec16({1'b0, ~arg, 1'b0});
              s_d.cnt    = 2'd0;
              s_d.last   = 2'd1;
              s_d.fsm    = csv_pkg::ST_PUSH;
            end
            csv_pkg::OP_SW_BREAK: begin
              // Break ignores the enable flag and shares table call 0's vector
              s_d.saved  = s_q.status_word | (8'h01 << csv_pkg::FL_BREAK);
              s_d.status_word[csv_pkg::FL_BREAK] = 1'b1;
              s_d.status_word[csv_pkg::FL_INT]   = 1'b0;
              s_d.target = vec16(csv_pkg::VEC_TBL0[5:0]);
              s_d.cnt    = 2'd0;
              s_d.last   = 2'd2;
              s_d.fsm    = csv_pkg::ST_PUSH;
            end
            csv_pkg::OP_INT_ACCEPT: begin
              if (!s_q.status_word[csv_pkg::FL_INT]) begin
                s_d.refused = 1'b1;
              end else begin
                s_d.saved  = s_q.status_word & ~(8'h01 << csv_pkg::FL_BREAK);
                s_d.status_word[csv_pkg::FL_INT]   = 1'b0;
                s_d.status_word[csv_pkg::FL_BREAK] = 1'b0;
                s_d.target = vec16(int_index(arg[2:0]));
                s_d.cnt    = 2'd0;
                s_d.last   = 2'd2;
                s_d.fsm    = csv_pkg::ST_PUSH;
              end
            end
            csv_pkg::OP_SUB_RETURN: begin
              s_d.cnt = 2'd1;
              s_d.fsm = csv_pkg::ST_POP;
            end
            csv_pkg::OP_INT_RETURN: begin
              s_d.cnt = 2'd0;
              s_d.fsm = csv_pkg::ST_POP;
            end
            csv_pkg::OP_STEP: s_d.pc = s_q.pc + 16'h0001;
            csv_pkg::OP_BOOT: s_d.fsm = csv_pkg::ST_BOOT;
            default: s_d.refused = 1'b0;
          endcase
        end
      end
      csv_pkg::ST_PUSH: begin
        // High byte, low byte, then the saved status word
        stk_we = 1'b1;
        stk_wd = (s_q.cnt == 2'd0) ? s_q.pc[15:8] :
                 (s_q.cnt == 2'd1) ? s_q.pc[7:0] : s_q.saved;
        s_d.stack_ptr = s_q.stack_ptr - 8'h01;
        s_d.cnt = s_q.cnt + 2'd1;
        if (s_q.cnt == s_q.last) begin
          s_d.pc  = s_q.target;
          s_d.fsm = csv_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.stack_ptr = pop_addr;
        s_d.cnt = s_q.cnt + 2'd1;
        if (s_q.cnt == 2'd0) begin
          s_d.status_word = pop_data;
        end else if (s_q.cnt == 2'd1) begin
          s_d.pc[7:0] = pop_data;
        end else begin
          s_d.pc[15:8] = pop_data;
          s_d.fsm = csv_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_q             <= '0;
      s_q.fsm         <= csv_pkg::ST_BOOT;
      s_q.status_word <= csv_pkg::STATUS_RESET;
      s_q.opnd        <= csv_pkg::OPND_RESET;
      s_q.daddr       <= csv_pkg::DATA_RESET;
      s_q.awready     <= 1'b1;
      s_q.wready      <= 1'b1;
      s_q.arready     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Stack bytes live at 100h plus the pointer; contents survive reset
  always_ff @(posedge CLK) begin
    if (stk_we) begin
      stack_mem[s_q.stack_ptr] <= stk_wd;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 16; i++) begin
        vec_mem[i] <= 32'h0000_0000;
      end
    end else if (vec_we) begin
      vec_mem[vec_wi] <= vec_wd;
    end
  end

  assign S_AXI_AWREADY = s_q.awready;
  assign S_AXI_WREADY  = s_q.wready;
  assign S_AXI_BVALID  = s_q.bvalid;
  assign S_AXI_BRESP   = s_q.bresp;
  assign S_AXI_ARREADY = s_q.arready;
  assign S_AXI_RVALID  = s_q.rvalid;
  assign S_AXI_RRESP   = s_q.rresp;
  assign S_AXI_RDATA   = s_q.rdata;

  irq_block_a: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && op == csv_pkg::OP_INT_ACCEPT && !s_q.status_word[csv_pkg::FL_INT]
    |=> s_q.refused && s_q.fsm == csv_pkg::ST_IDLE)
    else $error("interrupt taken while disabled");
  irq_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && op == csv_pkg::OP_INT_ACCEPT && s_q.status_word[csv_pkg::FL_INT]
    |=> !s_q.status_word[csv_pkg::FL_INT] && s_q.fsm == csv_pkg::ST_PUSH)
    else $error("enable flag not cleared on accept");
  ena_int_a: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && op == csv_pkg::OP_ENA_INT |=> s_q.status_word[csv_pkg::FL_INT])
    else $error("enable command did not set flag");
  ovf_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && op == csv_pkg::OP_CLR_OVF
    |=> !s_q.status_word[csv_pkg::FL_OVF] && !s_q.status_word[csv_pkg::FL_HALF])
    else $error("overflow or half carry not cleared");
  break_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && op == csv_pkg::OP_SW_BREAK |=> s_q.status_word[csv_pkg::FL_BREAK])
    else $error("break flag not set");
  pc_wrap_a: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && op == csv_pkg::OP_STEP && s_q.pc == 16'hffff |=> s_q.pc == 16'h0000)
    else $error("program counter did not wrap");
  push_dec_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_q.fsm == csv_pkg::ST_PUSH |=> s_q.stack_ptr == $past(s_q.stack_ptr) - 8'h01)
    else $error("stack pointer not decremented");
  pop_inc_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_q.fsm == csv_pkg::ST_POP |=> s_q.stack_ptr == $past(s_q.stack_ptr) + 8'h01)
    else $error("stack pointer not incremented");
  call_seq_a: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && op == csv_pkg::OP_CALL
    |=> s_q.fsm == csv_pkg::ST_PUSH [*2] ##1
        (s_q.fsm == csv_pkg::ST_IDLE && s_q.pc == $past(call_tgt, 3)))
    else $error("call sequence wrong");
  neg_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
    exec && (op == csv_pkg::OP_ADD || op == csv_pkg::OP_SUB)
    |=> s_q.status_word[csv_pkg::FL_NEG] == s_q.result[7])
    else $error("negative flag differs from result");
endmodule // csv_core
`default_nettype wire

/* File: csv_sw_model.sv */
// Software-side register bus master for the status, vector and stack block
`timescale 1ns/1ps
`default_nettype none
module csv_sw_model (
  // Clock
  input  wire logic        CLK,
  // Write channels
  output var  logic [7:0]  S_AXI_AWADDR,
  output var  logic        S_AXI_AWVALID,
  input  wire logic        S_AXI_AWREADY,
  output var  logic [31:0] S_AXI_WDATA,
  output var  logic [3:0]  S_AXI_WSTRB,
  output var  logic        S_AXI_WVALID,
  input  wire logic        S_AXI_WREADY,
  input  wire logic [1:0]  S_AXI_BRESP,
  input  wire logic        S_AXI_BVALID,
  output var  logic        S_AXI_BREADY,
  // Read channels
  output var  logic [7:0]  S_AXI_ARADDR,
  output var  logic        S_AXI_ARVALID,
  input  wire logic        S_AXI_ARREADY,
  input  wire logic [31:0] S_AXI_RDATA,
  input  wire logic [1:0]  S_AXI_RRESP,
  input  wire logic        S_AXI_RVALID,
  output var  logic        S_AXI_RREADY
);
  initial begin
    {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WSTRB, S_AXI_WVALID} = '0;
    {S_AXI_BREADY, S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = '0;
  end
  // Whole-word stores only, so no read-modify-write ever reaches the block
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= 4'hf;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY && S_AXI_AWVALID) begin
        S_AXI_AWVALID <= 1'b0;
        S_AXI_AWADDR <= ~a;
      end
      if (S_AXI_WREADY && S_AXI_WVALID) begin
        S_AXI_WVALID <= 1'b0;
        S_AXI_WDATA <= ~d;
      end
    end while (!S_AXI_BVALID);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY && S_AXI_ARVALID) begin
        S_AXI_ARVALID <= 1'b0;
        S_AXI_ARADDR <= ~a;
      end
    end while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
endmodule // csv_sw_model
`default_nettype wire

/* File: test_csv_core.sv */
// Self-checking bench for the status, vector and stack block
`timescale 1ns/1ps
`default_nettype none
module test_csv_core;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rv;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rs;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  csv_core dut (.*);
  csv_sw_model u_sw (.*);
  always #25 CLK = ~CLK;
  // Generous ceiling, a few hundred cycles are expected
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    u_sw.rd(a, rv, rs);
    chk(rv, e);
    chk({30'h0, rs}, {30'h0, csv_pkg::RESP_OKAY});
  endtask
  task automatic stc(input logic [31:0] m, input logic [31:0] e);
    u_sw.rd(csv_pkg::OFF_STAT, rv, rs);
    chk(rv & m, e);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    u_sw.wr(a, d, rs);
    chk({30'h0, rs}, {30'h0, csv_pkg::RESP_OKAY});
  endtask
  // Polls busy so the next command is never dropped
  task automatic cmd(input logic [4:0] op, input logic [3:0] arg);
    int i;
    wrr(csv_pkg::OFF_CMD, {20'h0, arg, 3'h0, op});
    for (i = 0; i < 20; i++) begin
      u_sw.rd(csv_pkg::OFF_STAT, rv, rs);
      if (rv[8] === 1'b0) break;
    end
    // Still busy after the polls counts as a hang
    chk({31'h0, rv[8]}, 32'h0);
  endtask
  task automatic t_boot;
    rdc(csv_pkg::OFF_PC, 32'h0);
    wrr(csv_pkg::OFF_VEC_HI, 32'h1234_0000);
    cmd(csv_pkg::OP_BOOT, 4'h0);
    rdc(csv_pkg::OFF_PC, 32'h1234);
    $display("t_boot done");
  endtask
  task automatic t_flags;
    cmd(csv_pkg::OP_ENA_INT, 4'h0);
    stc(32'h04, 32'h04);
    cmd(csv_pkg::OP_DIS_INT, 4'h0);
    stc(32'h04, 32'h00);
    cmd(csv_pkg::OP_SET_DP, 4'h0);
    wrr(csv_pkg::OFF_DADR, 32'hc0);
    stc(32'h01ff_0420, 32'h01c0_0020);
    cmd(csv_pkg::OP_CLR_DP, 4'h0);
    stc(32'h01ff_0420, 32'h00c0_0400);
    wrr(csv_pkg::OFF_DADR, 32'hbf);
    stc(32'h01ff_0420, 32'h00bf_0000);
    u_sw.wr(8'h30, 32'h0, rs);
    chk({30'h0, rs}, {30'h0, csv_pkg::RESP_SLVERR});
    u_sw.rd(8'h30, rv, rs);
    chk({30'h0, rs}, {30'h0, csv_pkg::RESP_SLVERR});
    $display("t_flags done");
  endtask
  task automatic t_arith;
    wrr(csv_pkg::OFF_OPND, 32'h017f);
    cmd(csv_pkg::OP_ADD, 4'h0);
    rdc(csv_pkg::OFF_RES, 32'h80);
    stc(32'hc8, 32'hc8);
    cmd(csv_pkg::OP_DIS_INT, 4'h0);
    stc(32'h48, 32'h48);
    cmd(csv_pkg::OP_CLR_OVF, 4'h0);
    stc(32'h48, 32'h00);
    wrr(csv_pkg::OFF_OPND, 32'h0180);
    cmd(csv_pkg::OP_SUB, 4'h0);
    stc(32'hc8, 32'h40);
    wrr(csv_pkg::OFF_OPND, 32'h4000);
    cmd(csv_pkg::OP_BIT_TEST, 4'h0);
    stc(32'hc0, 32'h40);
    wrr(csv_pkg::OFF_OPND, 32'h8000);
    cmd(csv_pkg::OP_BIT_TEST, 4'h0);
    stc(32'hc0, 32'h80);
    cmd(csv_pkg::OP_LOAD, 4'h0);
    rdc(csv_pkg::OFF_RES, 32'h80);
    stc(32'h82, 32'h80);
    cmd(csv_pkg::OP_NOP, 4'h0);
    stc(32'hff, 32'h81);
    $display("t_arith done");
  endtask
  task automatic t_stack;
    wrr(csv_pkg::OFF_STACK, 32'hff);
    wrr(csv_pkg::OFF_OPND, 32'h5555_0000);
    cmd(csv_pkg::OP_CALL, 4'h0);
    rdc(csv_pkg::OFF_PC, 32'h5555);
    rdc(csv_pkg::OFF_STACK, 32'hfd);
    cmd(csv_pkg::OP_SUB_RETURN, 4'h0);
    rdc(csv_pkg::OFF_PC, 32'h1234);
    rdc(csv_pkg::OFF_STACK, 32'hff);
    wrr(8'h78, 32'hbbbb_aaaa);
    cmd(csv_pkg::OP_DIS_INT, 4'h0);
    cmd(csv_pkg::OP_INT_ACCEPT, 4'h1);
    stc(32'h0204, 32'h0200);
    rdc(csv_pkg::OFF_PC, 32'h1234);
    cmd(csv_pkg::OP_ENA_INT, 4'h0);
    cmd(csv_pkg::OP_INT_ACCEPT, 4'h1);
    rdc(csv_pkg::OFF_PC, 32'haaaa);
    stc(32'h0204, 32'h0000);
    rdc(csv_pkg::OFF_STACK, 32'hfc);
    cmd(csv_pkg::OP_INT_RETURN, 4'h0);
    rdc(csv_pkg::OFF_PC, 32'h1234);
    stc(32'hff, 32'h85);
    cmd(csv_pkg::OP_INT_ACCEPT, 4'h0);
    rdc(csv_pkg::OFF_PC, 32'hbbbb);
    $display("t_stack done");
  endtask
  task automatic t_vect;
    wrr(csv_pkg::OFF_VEC_LO, 32'h2222_ffff);
    cmd(csv_pkg::OP_TBL_CALL, 4'he);
    rdc(csv_pkg::OFF_PC, 32'h2222);
    cmd(csv_pkg::OP_TBL_CALL, 4'hf);
    rdc(csv_pkg::OFF_PC, 32'hffff);
    cmd(csv_pkg::OP_STEP, 4'h0);
    rdc(csv_pkg::OFF_PC, 32'h0000);
    wrr(8'h5c, 32'h7777_0000);
    cmd(csv_pkg::OP_SW_BREAK, 4'h0);
    rdc(csv_pkg::OFF_PC, 32'h7777);
    stc(32'h14, 32'h10);
    $display("t_vect done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    t_boot();
    t_flags();
    t_arith();
    t_stack();
    t_vect();
    stop_test();
  end
endmodule // test_csv_core
`default_nettype wire
